/* logic/rcsd_params.svh */
`ifndef RCSD_PARAMS_SVH
`define RCSD_PARAMS_SVH

// number of divided output banks (output zero excluded)
`define RCSD_NBANK        6
// 3.5 pF expressed in 0.125 pF steps
`define RCSD_LOADCAP_BASE 7'd28
// quotient value that selects disable or divide by one
`define RCSD_QUOT_ALLONES 7'h7f
// secondary cycles without primary transitions before failover
`define RCSD_LOST_CYCLES  2'd2
// reference divider value that powers a PLL down
`define RCSD_DIV_OFF      7'h00
// lowest legal reference divider for the fourth PLL
`define RCSD_PLL3_MIN_DIV 7'h03
// output disable mode codes
`define RCSD_OEM_LOW      2'h0
`define RCSD_OEM_HIGH     2'h1

`endif

/* logic/rcsd_pkg.sv */
`include "rcsd_params.svh"

package rcsd_pkg;

	typedef enum logic {
		RCSD_SRC_PRIMARY,
		RCSD_SRC_SECONDARY
	} rcsd_src_e;

	typedef struct packed {
		logic [6:0]  refDiv;
		logic [11:0] fbInt;
		logic [3:0]  fbFrac;
	} rcsd_pll_cfg_s;

	typedef struct packed {
		logic [6:0] quotient;
		logic       dividerModeBit;
		logic [1:0] outputDisableMode;
	} rcsd_bank_cfg_s;

	typedef struct packed {
		rcsd_src_e                        active;
		logic                             prevPrim;
		logic                             prevSec;
		logic [1:0]                       secCount;
		logic                             lostPrimary;
		logic                             outZero;
		logic [`RCSD_NBANK-1:0][7:0]      bankCnt;
		logic [`RCSD_NBANK-1:0]           bankLvl;
		logic [`RCSD_NBANK-1:0]           bankData;
		logic [`RCSD_NBANK-1:0]           bankOe;
		logic [`RCSD_NBANK-1:0][8:0]      bankDiv;
		logic [6:0]                       loadCap;
		logic [3:0][13:0]                 fbTotal;
		logic [3:0]                       pllDown;
		logic                             pll3Illegal;
	} rcsd_state_s;

endpackage : rcsd_pkg

/* logic/rcsd_top.sv */
// Notes on behaviour
// - select bit 0 makes crystal input primary
// - mode field 0x gives manual pin selection
// - manual switch waits for low levels, glitchless
// - two secondary cycles without primary edge switch
// - return to primary as soon as it toggles
// - automatic switch is immediate, may leave pulses
// - load cap is 3.5 pF plus code eighths
// - seven-bit reference, twelve-bit feedback dividers
// - output is input times M over D over divider
// - first PLL M from integer and fraction
// - quotient and mode bit choose divider setting
// - disabled output follows disable mode, divider runs
// - output zero bypasses every output divider
// - dividers bypass or divide even 2 to 256
// - zero reference divider powers down PLLs 0-2
`timescale 1ns/1ps

module rcsd_top
	import rcsd_pkg::*;
(
	input  wire logic                                 ref_clk,
	input  wire logic                                 reset,
	input  wire logic                                 crystalRefInput,
	input  wire logic                                 secondClockInput,
	input  wire logic                                 inputSelectPin,
	input  wire logic                                 primarySourceSel,
	input  wire logic [1:0]                           switchoverModeField,
	input  wire logic [4:0]                           loadCapCode,
	input  wire rcsd_pll_cfg_s [3:0]                  pllCfg,
	input  wire rcsd_bank_cfg_s [`RCSD_NBANK-1:0]     bankCfg,
	output logic                                      outputZero,
	output logic [`RCSD_NBANK-1:0]                    bankData,
	output logic [`RCSD_NBANK-1:0]                    bankOe,
	output logic [`RCSD_NBANK-1:0][8:0]               bankDivTotal,
	output logic                                      onSecondary,
	output logic [6:0]                                loadCapEighths,
	output logic [3:0][13:0]                          pllFbTotal,
	output logic [3:0]                                pllPowerDown,
	output logic                                      pll3DivIllegal
);

	rcsd_state_s q;
	rcsd_state_s next_q;

	function automatic logic [8:0] rcsd_div_total(input logic [6:0] quot, input logic pm);
		logic [8:0] total;
		logic [7:0] qPlus;
		total = 9'h000;
		// widened first so a quotient of 7eh still reaches 256
		qPlus = {1'b0, quot} + 8'h02;
		if (quot == `RCSD_QUOT_ALLONES)
			total = pm ? 9'h001 : 9'h000;
		else if (pm)
			total = {qPlus, 1'b0};
		else
			total = 9'h002;
		return total;
	endfunction : rcsd_div_total

	function automatic logic [13:0] rcsd_fb_total0(input logic [11:0] n, input logic [3:0] a);
		logic [13:0] m;
		m = {1'b0, n, 1'b0};
		if (a != 4'h0)
			m = m + {10'h000, a} + 14'h0001;
		return m;
	endfunction : rcsd_fb_total0

	logic      primIn;
	logic      secIn;
	logic      autoMode;
	logic      primEdge;
	logic      secRise;
	rcsd_src_e wanted;
	logic      refRise;
	logic [7:0] half;

	assign primIn   = primarySourceSel ? secondClockInput : crystalRefInput;
	assign secIn    = primarySourceSel ? crystalRefInput : secondClockInput;
	assign autoMode = switchoverModeField[1];
	assign primEdge = primIn != q.prevPrim;
	assign secRise  = secIn & ~q.prevSec;

	always_comb begin
		next_q = q;
		wanted = RCSD_SRC_PRIMARY;
		refRise = 1'b0;
		half = 8'h00;
		next_q.prevPrim = primIn;
		next_q.prevSec = secIn;
		// missing-primary watch, counted in secondary cycles
		if (primEdge) begin
			next_q.secCount = 2'd0;
			next_q.lostPrimary = 1'b0;
		end else if (secRise && q.secCount != `RCSD_LOST_CYCLES) begin
			next_q.secCount = q.secCount + 2'd1;
			if (q.secCount + 2'd1 == `RCSD_LOST_CYCLES)
				next_q.lostPrimary = 1'b1;
		end
		if (autoMode) begin
			wanted = next_q.lostPrimary ? RCSD_SRC_SECONDARY : RCSD_SRC_PRIMARY;
			next_q.active = wanted;
		end else begin
			wanted = inputSelectPin ? RCSD_SRC_SECONDARY : RCSD_SRC_PRIMARY;
			// swap only while both levels are low so no runt pulse leaves
			if (wanted != q.active && !q.outZero && !(wanted == RCSD_SRC_PRIMARY ? primIn : secIn))
				next_q.active = wanted;
		end
		next_q.outZero = (next_q.active == RCSD_SRC_PRIMARY) ? primIn : secIn;
		refRise = next_q.outZero & ~q.outZero;
		for (int b = 0; b < `RCSD_NBANK; b++) begin
			next_q.bankDiv[b] = rcsd_div_total(bankCfg[b].quotient, bankCfg[b].dividerModeBit);
			half = next_q.bankDiv[b][8:1];
			// counter keeps running even when the bank is disabled
			if (refRise) begin
				if (q.bankCnt[b] + 8'h01 >= half) begin
					next_q.bankCnt[b] = 8'h00;
					next_q.bankLvl[b] = ~q.bankLvl[b];
				end else begin
					next_q.bankCnt[b] = q.bankCnt[b] + 8'h01;
				end
			end
			if (next_q.bankDiv[b] == 9'h000) begin
				next_q.bankOe[b] = bankCfg[b].outputDisableMode == `RCSD_OEM_LOW ||
						bankCfg[b].outputDisableMode == `RCSD_OEM_HIGH;
				next_q.bankData[b] = bankCfg[b].outputDisableMode == `RCSD_OEM_HIGH;
			end else if (next_q.bankDiv[b] == 9'h001) begin
				next_q.bankOe[b] = 1'b1;
				next_q.bankData[b] = next_q.outZero;
			end else begin
				next_q.bankOe[b] = 1'b1;
				next_q.bankData[b] = next_q.bankLvl[b];
			end
		end
		next_q.loadCap = `RCSD_LOADCAP_BASE + {2'b00, loadCapCode};
		next_q.fbTotal[0] = rcsd_fb_total0(pllCfg[0].fbInt, pllCfg[0].fbFrac);
		for (int p = 1; p < 4; p++)
			next_q.fbTotal[p] = {2'b00, pllCfg[p].fbInt};
		for (int p = 0; p < 3; p++)
			next_q.pllDown[p] = pllCfg[p].refDiv == `RCSD_DIV_OFF;
		next_q.pllDown[3] = 1'b0;
		next_q.pll3Illegal = pllCfg[3].refDiv < `RCSD_PLL3_MIN_DIV;
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset)
			q <= '0;
		else
			q <= next_q;
	end

	assign outputZero     = q.outZero;
	assign bankData       = q.bankData;
	assign bankOe         = q.bankOe;
	assign bankDivTotal   = q.bankDiv;
	assign onSecondary    = q.active;
	assign loadCapEighths = q.loadCap;
	assign pllFbTotal     = q.fbTotal;
	assign pllPowerDown   = q.pllDown;
	assign pll3DivIllegal = q.pll3Illegal;

	prim_map_a: assert property (@(posedge ref_clk) disable iff (reset)
		(!autoMode && q.active == RCSD_SRC_PRIMARY && !primarySourceSel) ##1 (q.active == RCSD_SRC_PRIMARY)
		|-> outputZero == $past(crystalRefInput))
		else $error("primary path does not follow crystal input");

	manual_pin_a: assert property (@(posedge ref_clk) disable iff (reset)
		(!autoMode && !inputSelectPin && q.active == RCSD_SRC_PRIMARY) |=> !onSecondary)
		else $error("manual mode left primary without pin request");

	glitch_free_a: assert property (@(posedge ref_clk) disable iff (reset)
		($changed(q.active) && !$past(autoMode)) |-> (!$past(q.outZero) && !outputZero))
		else $error("manual switch happened on a high level");

	lost_switch_a: assert property (@(posedge ref_clk) disable iff (reset)
		(autoMode && !primEdge && secRise && q.secCount == 2'd1) |=> onSecondary)
		else $error("missing primary not followed by switch");

	revert_a: assert property (@(posedge ref_clk) disable iff (reset)
		(autoMode && primEdge) |=> (autoMode |-> !onSecondary))
		else $error("primary transition did not restore primary");

	load_cap_a: assert property (@(posedge ref_clk) disable iff (reset)
		(loadCapCode == 5'h1f) |=> loadCapEighths == 7'd59)
		else $error("load capacitance code mapping wrong");

	fb_even_a: assert property (@(posedge ref_clk) disable iff (reset)
		(pllCfg[0].fbFrac == 4'h0) |=> pllFbTotal[0] == {1'b0, $past(pllCfg[0].fbInt), 1'b0})
		else $error("first PLL feedback wrong with zero fraction");

	bank_off_a: assert property (@(posedge ref_clk) disable iff (reset)
		(bankCfg[1].quotient == 7'h7f && !bankCfg[1].dividerModeBit && bankCfg[1].outputDisableMode == 2'h1)
		|=> (bankOe[1] && bankData[1] && bankDivTotal[1] == 9'h000))
		else $error("disabled bank not driven high");

	bypass_copy_a: assert property (@(posedge ref_clk) disable iff (reset)
		(bankDivTotal[3] == 9'h001) |-> bankData[3] == outputZero)
		else $error("bypassed bank does not copy output zero");

	fb_frac_a: assert property (@(posedge ref_clk) disable iff (reset)
		(pllCfg[0].fbFrac != 4'h0) |=> pllFbTotal[0] ==
		{1'b0, $past(pllCfg[0].fbInt), 1'b0} + {10'h000, $past(pllCfg[0].fbFrac)} + 14'h0001)
		else $error("first PLL feedback wrong with nonzero fraction");

	pll3_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
		(pllCfg[3].refDiv < 7'h03) |=> pll3DivIllegal)
		else $error("illegal fourth PLL divider not flagged");

	pll3_ok_a: assert property (@(posedge ref_clk) disable iff (reset)
		(pllCfg[3].refDiv >= 7'h03) |=> (!pll3DivIllegal && !pllPowerDown[3]))
		else $error("legal fourth PLL divider flagged or powered down");

	div_range_a: assert property (@(posedge ref_clk) disable iff (reset)
		bankDivTotal[0] <= 9'h001 || (!bankDivTotal[0][0] && bankDivTotal[0] <= 9'h100))
		else $error("output divide outside even 2 to 256");

	pll_down_a: assert property (@(posedge ref_clk) disable iff (reset)
		(pllCfg[1].refDiv == 7'h00) |=> pllPowerDown[1])
		else $error("zero reference divider did not power down");

endmodule : rcsd_top

/* bench/rcsd_clk_src.sv */
`timescale 1ns/1ps

module rcsd_clk_src #(
	parameter int PRIM_HALF = 2,
	parameter int SEC_HALF  = 3
) (
	input  wire logic ref_clk,
	input  wire logic runPrim,
	input  wire logic runSec,
	output logic      primClk,
	output logic      secClk
);
	int primCnt = 0;
	int secCnt  = 0;

	initial begin
		primClk = 1'b0;
		secClk = 1'b0;
	end

	// stopped sources hold their level; secondary never faster than primary
	always @(posedge ref_clk) begin
		primCnt <= (primCnt + 1) % PRIM_HALF;
		secCnt <= (secCnt + 1) % SEC_HALF;
		if (runPrim && primCnt == PRIM_HALF - 1) begin
			primClk <= ~primClk;
		end
		if (runSec && secCnt == SEC_HALF - 1) begin
			secClk <= ~secClk;
		end
	end
endmodule : rcsd_clk_src

/* bench/testbench.sv */
`timescale 1ns/1ps
`include "rcsd_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module testbench
	import rcsd_pkg::*;
;
	logic                              ref_clk = 1'b0;
	logic                              reset = 1'b1;
	logic                              runPrim = 1'b1;
	logic                              runSec = 1'b1;
	logic                              crystalRefInput;
	logic                              secondClockInput;
	logic                              inputSelectPin = 1'b0;
	logic                              primarySourceSel = 1'b0;
	logic [1:0]                        switchoverModeField = 2'h0;
	logic [4:0]                        loadCapCode = 5'h00;
	rcsd_pll_cfg_s [3:0]               pllCfg = '{4{'{7'h01, 12'h005, 4'h0}}};
	rcsd_bank_cfg_s [`RCSD_NBANK-1:0]  bankCfg = '{`RCSD_NBANK{'{7'h7f, 1'b1, 2'h0}}};
	logic                              outputZero;
	logic [`RCSD_NBANK-1:0]            bankData;
	logic [`RCSD_NBANK-1:0]            bankOe;
	logic [`RCSD_NBANK-1:0][8:0]       bankDivTotal;
	logic                              onSecondary;
	logic [6:0]                        loadCapEighths;
	logic [3:0][13:0]                  pllFbTotal;
	logic [3:0]                        pllPowerDown;
	logic                              pll3DivIllegal;
	int                                fails = 0;
	int                                tests_run = 0;

	always #5 ref_clk = ~ref_clk;

	rcsd_clk_src u_src (.ref_clk(ref_clk), .runPrim(runPrim), .runSec(runSec),
		.primClk(crystalRefInput), .secClk(secondClockInput));

	rcsd_top u_dut (.ref_clk(ref_clk), .reset(reset), .crystalRefInput(crystalRefInput),
		.secondClockInput(secondClockInput), .inputSelectPin(inputSelectPin),
		.primarySourceSel(primarySourceSel), .switchoverModeField(switchoverModeField),
		.loadCapCode(loadCapCode), .pllCfg(pllCfg), .bankCfg(bankCfg), .outputZero(outputZero),
		.bankData(bankData), .bankOe(bankOe), .bankDivTotal(bankDivTotal), .onSecondary(onSecondary),
		.loadCapEighths(loadCapEighths), .pllFbTotal(pllFbTotal), .pllPowerDown(pllPowerDown),
		.pll3DivIllegal(pll3DivIllegal));

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task automatic wait_sec(input logic want);
		int n;
		n = 0;
		while (onSecondary !== want && n < 40) begin
			step(1);
			n++;
		end
		`CHK("onSecondary", want, onSecondary)
	endtask : wait_sec

	task automatic test_load_cap();
		logic [4:0] codes [3] = '{5'h03, 5'h1f, 5'h00};
		foreach (codes[i]) begin
			loadCapCode = codes[i];
			step(2);
			`CHK("loadCapEighths", 7'h1c + {2'h0, codes[i]}, loadCapEighths)
		end
	endtask : test_load_cap

	task automatic test_pll();
		pllCfg[0] = '{7'h00, 12'h005, 4'h0};
		pllCfg[1] = '{7'h00, 12'hfff, 4'h0};
		pllCfg[3] = '{7'h02, 12'h00c, 4'h0};
		step(2);
		`CHK("pllFbTotal0", 14'h000a, pllFbTotal[0])
		`CHK("pllFbTotal1", 14'h0fff, pllFbTotal[1])
		`CHK("pllPowerDown", 4'h3, pllPowerDown)
		`CHK("pll3DivIllegal", 1'b1, pll3DivIllegal)
		pllCfg = '{4{'{7'h03, 12'h00c, 4'h3}}};
		step(2);
		`CHK("pllFbTotal0", 14'h001c, pllFbTotal[0])
		`CHK("pllPowerDown", 4'h0, pllPowerDown)
		`CHK("pll3DivIllegal", 1'b0, pll3DivIllegal)
	endtask : test_pll

	task automatic test_banks();
		int rises;
		int flips;
		logic pz;
		logic pd;
		// low banks unused here, so only they get disabled
		bankCfg = '{'{7'h7e, 1'b1, 2'h0}, '{7'h05, 1'b0, 2'h0}, '{7'h7f, 1'b1, 2'h0},
			'{7'h7f, 1'b0, 2'h2}, '{7'h7f, 1'b0, 2'h1}, '{7'h7f, 1'b0, 2'h0}};
		step(20);
		rises = 0;
		flips = 0;
		pz = outputZero;
		pd = bankData[4];
		repeat (16) begin
			step(1);
			rises += int'(outputZero === 1'b1 && pz === 1'b0);
			flips += int'(bankData[4] !== pd);
			pz = outputZero;
			pd = bankData[4];
		end
		`CHK("bank4 divide-by-2 flips", rises, flips)
		`CHK("bank4 saw rises", 1'b1, rises > 0)
		`CHK("bank3 bypass copy", outputZero, bankData[3])
		`CHK("bankDivTotal", {9'h100, 9'h002, 9'h001, 9'h000, 9'h000, 9'h000}, bankDivTotal)
		`CHK("bankOe low bits", 3'h3, bankOe[2:0])
		`CHK("bankData low bits", 3'h2, bankData[2:0] & bankOe[2:0])
		bankCfg[0] = '{7'h00, 1'b1, 2'h0};
		step(2);
		`CHK("bankDivTotal0", 9'h004, bankDivTotal[0])
	endtask : test_banks

	task automatic test_manual();
		int t;
		logic p;
		inputSelectPin = 1'b1;
		wait_sec(1'b1);
		inputSelectPin = 1'b0;
		wait_sec(1'b0);
		primarySourceSel = 1'b1;
		runPrim = 1'b0;
		t = 0;
		step(4);
		p = outputZero;
		repeat (20) begin
			step(1);
			t += int'(outputZero !== p);
			p = outputZero;
		end
		`CHK("outputZero toggles", 1'b1, t > 0)
		primarySourceSel = 1'b0;
		runPrim = 1'b1;
		step(4);
	endtask : test_manual

	task automatic test_auto();
		switchoverModeField = 2'h3;
		step(10);
		`CHK("onSecondary", 1'b0, onSecondary)
		runPrim = 1'b0;
		wait_sec(1'b1);
		runPrim = 1'b1;
		wait_sec(1'b0);
		switchoverModeField = 2'h0;
	endtask : test_auto

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge ref_clk);
		fails++;
		tally_and_finish();
	end

	initial begin
		step(8);
		`CHK("onSecondary in reset", 1'b0, onSecondary)
		reset = 1'b0;
		test_load_cap();
		test_pll();
		test_banks();
		test_manual();
		test_auto();
		tally_and_finish();
	end
endmodule : testbench
